/* File: core/slt_map.vh */
// Register map, field positions, reset values and FIFO depth for the
// synchronous line transmit control. Assumes a 32-bit APB register bus.
// Notes on behaviour
// - Length counter loads minus bits, counts up.
// - Overflow carry reloads counters, starts next character.
// - Bit counter loads zero, selects serializer input.
// - Bits per character from misc bits 8-11.
// - Four-bit counters advance on rising bit clock edges.
// - Load when inactive or on overflow; no counting.
// - Carry high at minus one, low at overflow.
// - Priority: escape, check, sync, data, pad.
// - Enable mux drives sync and data bytes.
// - Double mode sends both data bytes in turn.
// - Transparent idle repeats escape then sync.
// - VRC sets top bit on parity error.
// - Odd count skips empty byte, ends early.
// - Data enable at start; DMA request per transfer.
// - Active while any character remains to send.
// - Line held at mark when not transmitting.
`ifndef SLT_MAP_VH
`define SLT_MAP_VH
`define SLT_OFS_CTRL    8'h00
`define SLT_OFS_MISC    8'h04
`define SLT_OFS_SYNC    8'h08
`define SLT_OFS_DATA    8'h0c
`define SLT_OFS_REQ     8'h10
`define SLT_OFS_ESC     8'h14
`define SLT_OFS_BCC     8'h18
`define SLT_OFS_STATUS  8'h1c
`define SLT_CTRL_GO     0
`define SLT_CTRL_DOUBLE 1
`define SLT_CTRL_TRANSP 2
`define SLT_CTRL_VRC    3
`define SLT_CTRL_ODD    4
`define SLT_CTRL_SYNC   5
`define SLT_CTRL_PAD    6
`define SLT_CTRL_AUTOB  7
`define SLT_MISC_BITS_LO 8
`define SLT_DATA_LAST   16
`define SLT_REQ_ESC     0
`define SLT_REQ_BCC     1
`define SLT_CTRL_RESET  8'h00
`define SLT_MISC_RESET  4'h8
`define SLT_SYNC_RESET  16'h0000
`define SLT_ESC_RESET   16'h0000
`define SLT_BCC_RESET   16'h0000
`define SLT_PAD_CHAR    16'hffff
`define SLT_FIFO_DEPTH  8
`endif

/* File: core/slt_tx_ctrl.v */
// Transmit control for a synchronous serial line, with its data FIFO.
// Assumes an APB master on ref_clk and a modem bit clock on tx_bit_clk.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "slt_map.vh"

module slt_fifo #(
    parameter W = 17,
    parameter D = `SLT_FIFO_DEPTH,
    parameter AW = 3
) (
    // Clock and reset.
    input  wire         clk,
    input  wire         resetn,
    // Filling side.
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // Draining side.
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0]   count;
    wire push;
    wire pop;
    assign in_ready  = (count != D[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // slt_fifo

module slt_tx_ctrl (
    // Clock and reset.
    input  wire        ref_clk,
    input  wire        resetn,
    // APB slave.
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Modem link.
    input  wire        tx_bit_clk,
    output reg         txd,
    // Character enables to the holding registers.
    output reg         esc_en,
    output reg         bcc_en,
    output reg         sync_en,
    output reg         data_en,
    output reg  [1:0]  sync_byte_en,
    output reg  [1:0]  data_byte_en,
    // Events and state.
    output reg         length_carry_pulse,
    output reg         dma_request,
    output reg         fake_end,
    output reg         tx_active
);
    localparam SEL_NONE = 3'd0;
    localparam SEL_ESC  = 3'd1;
    localparam SEL_BCC  = 3'd2;
    localparam SEL_SYNC = 3'd3;
    localparam SEL_DATA = 3'd4;
    localparam SEL_PAD  = 3'd5;
    // Bits wanted in a character of n bits; zero selects sixteen.
    function [15:0] char_mask;
        input [3:0] n;
        begin
            char_mask = (n == 4'h0) ? 16'hffff
                                    : ((16'h0001 << n) - 16'h0001);
        end
    endfunction
    // Registers.
    reg [7:0]  ctrl;
    reg [3:0]  bits_per_char;
    reg [15:0] sync_reg;
    reg [15:0] esc_char;
    reg [15:0] bcc_char;
    reg        esc_req;
    reg        bcc_req;
    // Bit clock synchroniser and edge finder.
    reg        clk_s1;
    reg        clk_s2;
    reg        clk_s3;
    reg        clk_level;
    wire       bit_tick;
    // Transmit state.
    reg [3:0]  char_length_counter;
    reg [3:0]  bit_position_counter;
    reg [15:0] char_reg;
    reg        byte_sel;
    reg        idle_phase;
    wire       counter_load_control;
    wire       carry;
    wire       slot;
    // FIFO.
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [16:0] fifo_out_data;
    wire        fifo_push;
    reg         fifo_pop;
    // Decision.
    reg [2:0]  next_sel;
    reg [15:0] next_char;
    reg        next_byte_sel;
    reg        next_idle_phase;
    reg        next_fake;
    reg [15:0] raw;
    reg [15:0] low_bits;
    reg        parity;
    wire go          = ctrl[`SLT_CTRL_GO];
    wire double_mode = ctrl[`SLT_CTRL_DOUBLE];
    wire transparent = ctrl[`SLT_CTRL_TRANSP];
    wire have_data   = go & fifo_out_valid;
    wire idle_fill   = go & ~fifo_out_valid;
    wire wide_char   = (bits_per_char == 4'h0) | (bits_per_char > 4'h8);
    wire odd_last    = fifo_out_data[`SLT_DATA_LAST];
    // APB access phase and its completing edge.
    wire access   = psel & penable;
    wire wr_done  = access & pready & pwrite;
    wire is_data  = (paddr == `SLT_OFS_DATA);
    wire wr_req   = wr_done & (paddr == `SLT_OFS_REQ);
    assign fifo_push = wr_done & is_data;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clk_s1    <= 1'b0;
            clk_s2    <= 1'b0;
            clk_s3    <= 1'b0;
            clk_level <= 1'b0;
        end else begin
            clk_s1 <= tx_bit_clk;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            if (clk_s2 == clk_s3) begin
                clk_level <= clk_s3;
            end
        end
    end
    // Rising edge once the second and third stages agree high.
    assign bit_tick = clk_s2 & clk_s3 & ~clk_level;
    // Carry is high at minus one; the next tick reloads minus the bit count.
    assign carry = tx_active & (char_length_counter == 4'hf);
    assign counter_load_control = ~tx_active | carry;
    assign slot = bit_tick & counter_load_control;
    // Priority choice of the next character and its contents.
    always @* begin
        next_sel        = SEL_NONE;
        next_char       = 16'h0000;
        next_byte_sel   = byte_sel;
        next_idle_phase = idle_phase;
        next_fake       = 1'b0;
        fifo_pop        = 1'b0;
        raw             = 16'h0000;
        low_bits        = 16'h0000;
        parity          = 1'b0;
        if (esc_req | (transparent & idle_fill & ~idle_phase)) begin
            next_sel  = SEL_ESC;
            next_char = esc_char;
            if (~esc_req) begin
                next_idle_phase = 1'b1;
            end
        end else if (bcc_req) begin
            next_sel  = SEL_BCC;
            next_char = bcc_char;
        end else if (idle_fill & (transparent ? idle_phase
                                              : ctrl[`SLT_CTRL_SYNC])) begin
            next_sel        = SEL_SYNC;
            next_char       = sync_reg;
            next_idle_phase = 1'b0;
        end else if (have_data) begin
            next_sel = SEL_DATA;
            if (double_mode) begin
                raw = byte_sel ? {8'h00, fifo_out_data[15:8]}
                               : {8'h00, fifo_out_data[7:0]};
                if (byte_sel | odd_last) begin
                    fifo_pop      = 1'b1;
                    next_byte_sel = 1'b0;
                    next_fake     = ~byte_sel;
                end else begin
                    next_byte_sel = 1'b1;
                end
            end else begin
                raw      = fifo_out_data[15:0];
                fifo_pop = 1'b1;
            end
            // The top bit of the character is forced when parity fails.
            low_bits = raw & (char_mask(bits_per_char) >> 1);
            parity   = ^low_bits;
            next_char = raw;
            if (ctrl[`SLT_CTRL_VRC] & (parity ^ ctrl[`SLT_CTRL_ODD])) begin
                next_char = raw | (char_mask(bits_per_char) &
                            ~(char_mask(bits_per_char) >> 1));
            end
        end else if (go & ctrl[`SLT_CTRL_PAD]) begin
            next_sel  = SEL_PAD;
            next_char = `SLT_PAD_CHAR;
        end
        next_char = next_char & char_mask(bits_per_char);
    end
    // Counters, send enables and serial data.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_active            <= 1'b0;
            char_length_counter  <= 4'h0;
            bit_position_counter <= 4'h0;
            char_reg             <= 16'h0000;
            byte_sel             <= 1'b0;
            idle_phase           <= 1'b0;
            esc_en               <= 1'b0;
            bcc_en               <= 1'b0;
            sync_en              <= 1'b0;
            data_en              <= 1'b0;
            sync_byte_en         <= 2'b00;
            data_byte_en         <= 2'b00;
            length_carry_pulse   <= 1'b0;
            dma_request          <= 1'b0;
            fake_end             <= 1'b0;
            txd                  <= 1'b1;
        end else begin
            length_carry_pulse <= bit_tick & carry;
            dma_request        <= 1'b0;
            fake_end           <= 1'b0;
            if (bit_tick) begin
                if (counter_load_control) begin
                    char_length_counter  <= 4'h0 - bits_per_char;
                    bit_position_counter <= 4'h0;
                end else begin
                    char_length_counter  <= char_length_counter + 4'h1;
                    bit_position_counter <= bit_position_counter + 4'h1;
                end
            end
            if (slot) begin
                tx_active  <= (next_sel != SEL_NONE);
                char_reg   <= next_char;
                byte_sel   <= next_byte_sel;
                idle_phase <= next_idle_phase;
                esc_en     <= (next_sel == SEL_ESC);
                bcc_en     <= (next_sel == SEL_BCC);
                sync_en    <= (next_sel == SEL_SYNC);
                data_en    <= (next_sel == SEL_DATA);
                dma_request <= fifo_pop;
                fake_end    <= next_fake;
                sync_byte_en <= (next_sel != SEL_SYNC) ? 2'b00 :
                                (wide_char ? 2'b11 : 2'b01);
                if (next_sel != SEL_DATA) begin
                    data_byte_en <= 2'b00;
                end else if (double_mode) begin
                    data_byte_en <= byte_sel ? 2'b10 : 2'b01;
                end else begin
                    data_byte_en <= wide_char ? 2'b11 : 2'b01;
                end
            end
            // Mark whenever no character is on the line.
            txd <= tx_active ? char_reg[bit_position_counter]
                             : 1'b1;
        end
    end
    slt_fifo #(
        .W  (17),
        .D  (`SLT_FIFO_DEPTH),
        .AW (3)
    ) u_fifo (
        .clk       (ref_clk),
        .resetn    (resetn),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata[16:0]),
        .out_valid (fifo_out_valid),
        .out_ready (slot & fifo_pop),
        .out_data  (fifo_out_data)
    );
    // APB slave: answer one cycle into the access phase; a data write
    // waits while the FIFO is full, which is the refill back-pressure.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            prdata        <= 32'h00000000;
            ctrl          <= `SLT_CTRL_RESET;
            bits_per_char <= `SLT_MISC_RESET;
            sync_reg      <= `SLT_SYNC_RESET;
            esc_char      <= `SLT_ESC_RESET;
            bcc_char      <= `SLT_BCC_RESET;
            esc_req       <= 1'b0;
            bcc_req       <= 1'b0;
        end else begin
            pready  <= access & ~pready & ~(pwrite & is_data & ~fifo_in_ready);
            pslverr <= 1'b0;
            if (access & ~pready) begin
                prdata <= 32'h00000000;
                if (paddr == `SLT_OFS_CTRL) begin
                    prdata <= {24'h000000, ctrl};
                end else if (paddr == `SLT_OFS_MISC) begin
                    prdata <= {20'h00000, bits_per_char, 8'h00};
                end else if (paddr == `SLT_OFS_SYNC) begin
                    prdata <= {16'h0000, sync_reg};
                end else if (paddr == `SLT_OFS_REQ) begin
                    prdata <= {30'h0000000, bcc_req, esc_req};
                end else if (paddr == `SLT_OFS_ESC) begin
                    prdata <= {16'h0000, esc_char};
                end else if (paddr == `SLT_OFS_BCC) begin
                    prdata <= {16'h0000, bcc_char};
                end else if (paddr == `SLT_OFS_STATUS) begin
                    prdata <= {26'h000000, byte_sel, idle_phase,
                               fifo_in_ready, fifo_out_valid, go,
                               tx_active};
                end else if (paddr != `SLT_OFS_DATA) begin
                    pslverr <= ~(pwrite & is_data & ~fifo_in_ready);
                end
            end
            if (wr_done) begin
                if (paddr == `SLT_OFS_CTRL) begin
                    ctrl <= pwdata[7:0];
                end else if (paddr == `SLT_OFS_MISC) begin
                    bits_per_char <= pwdata[`SLT_MISC_BITS_LO+3:
                                            `SLT_MISC_BITS_LO];
                end else if (paddr == `SLT_OFS_SYNC) begin
                    sync_reg <= pwdata[15:0];
                end else if (paddr == `SLT_OFS_ESC) begin
                    esc_char <= pwdata[15:0];
                end else if (paddr == `SLT_OFS_BCC) begin
                    bcc_char <= pwdata[15:0];
                end
            end
            // A software set wins over the clear by a sent character.
            esc_req <= (esc_req & ~(slot & (next_sel == SEL_ESC))) |
                       (wr_req & pwdata[`SLT_REQ_ESC]);
            bcc_req <= (bcc_req & ~(slot & (next_sel == SEL_BCC))) |
                       (wr_req & pwdata[`SLT_REQ_BCC]) |
                       (slot & next_fake & ctrl[`SLT_CTRL_AUTOB]);
        end
    end
endmodule // slt_tx_ctrl

/* File: verification/slt_tx_ctrl_asserts.sv */
// Assertions on the serial and event outputs of the transmit control.
// Assumes one ref_clk domain and the bind at the foot of this file.
`timescale 1ns/100ps
module slt_tx_ctrl_chk (
    // Clock and reset.
    input wire logic       ref_clk,
    input wire logic       resetn,
    // Observed outputs.
    input wire logic       txd,
    input wire logic       esc_en,
    input wire logic       bcc_en,
    input wire logic       sync_en,
    input wire logic [1:0] sync_byte_en,
    input wire logic       data_en,
    input wire logic [1:0] data_byte_en,
    input wire logic       length_carry_pulse,
    input wire logic       dma_request,
    input wire logic       fake_end,
    input wire logic       tx_active
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    property p_one_char;
        $onehot0({esc_en, bcc_en, sync_en, data_en});
    endproperty
    a_one_char: assert property (p_one_char)
        else $error("two character types enabled");
    // One cycle of slack covers the register between state and line.
    property p_mark_idle;
        (!tx_active && !$past(tx_active)) |-> txd;
    endproperty
    a_mark_idle: assert property (p_mark_idle)
        else $error("line not at mark while idle");
    property p_quiet_idle;
        (!tx_active && !$past(tx_active)) |-> !(esc_en || bcc_en ||
            sync_en || data_en);
    endproperty
    a_quiet_idle: assert property (p_quiet_idle)
        else $error("character enabled while inactive");
    // The shortest character is one bit, eight ref_clk cycles or more.
    property p_carry_gap;
        length_carry_pulse |=> !length_carry_pulse [*6];
    endproperty
    a_carry_gap: assert property (p_carry_gap)
        else $error("carry pulses too close");
    property p_carry_active;
        length_carry_pulse |-> $past(tx_active);
    endproperty
    a_carry_active: assert property (p_carry_active)
        else $error("carry while counters held in load");
    property p_dma_data;
        dma_request |-> ##[0:1] data_en;
    endproperty
    a_dma_data: assert property (p_dma_data)
        else $error("refill request without data enable");
    property p_fake_data;
        fake_end |-> ##[0:1] data_en;
    endproperty
    a_fake_data: assert property (p_fake_data)
        else $error("early end outside a data character");
    property p_byte_sel;
        $rose(data_en) |-> data_byte_en != 2'b00;
    endproperty
    a_byte_sel: assert property (p_byte_sel)
        else $error("data enabled with no byte selected");
    property p_sync_bytes;
        sync_en == (sync_byte_en != 2'b00);
    endproperty
    a_sync_bytes: assert property (p_sync_bytes)
        else $error("sync byte enables disagree with sync enable");
endmodule // slt_tx_ctrl_chk

bind slt_tx_ctrl slt_tx_ctrl_chk i_chk (
    .ref_clk, .resetn, .txd, .esc_en, .bcc_en, .sync_en, .data_en,
    .sync_byte_en, .data_byte_en, .length_carry_pulse, .dma_request,
    .fake_end, .tx_active
);

/* File: verification/slt_modem.sv */
// Model of the synchronous modem on the far side of the serial line.
// Assumes txd is settled at each rising edge of the clock it supplies.
`timescale 1ns/100ps
module slt_modem (
    // Serial line.
    output logic      tx_bit_clk,
    input  wire logic txd
);
    logic bits[$];
    logic locked = 1'b0;
    // A modem's transmit clock runs free, here in a phase unrelated
    // to ref_clk so that no edge of the two ever coincides.
    initial begin
        tx_bit_clk = 1'b0;
        #137;
        forever #400 tx_bit_clk = ~tx_bit_clk;
    end
    // Hunting for the first space bit aligns the characters.
    always @(posedge tx_bit_clk) begin
        if (locked || txd === 1'b0) begin
            locked = 1'b1;
            bits.push_back(txd);
        end
    end
endmodule // slt_modem

/* File: verification/tb_top.sv */
// Self-checking bench for the synchronous line transmit control.
// Assumes slt_modem on the line and this module as APB master.
`timescale 1ns/100ps
module tb_top;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, w;
    logic        pready, pslverr, txd, tx_bit_clk, e;
    logic        esc_en, bcc_en, sync_en, data_en, fake_end, tx_active;
    logic [1:0]  sync_byte_en, data_byte_en;
    logic        length_carry_pulse, dma_request;
    logic [7:0]  cur_ctrl;
    logic        exp_q[$];
    logic [7:0]  ctrl_t[5] = '{8'h01, 8'h01, 8'h01, 8'h09, 8'h19};
    int          n_t[5] = '{8, 12, 5, 8, 8};
    int          cur_n, err_total, checked, n_dma, n_carry, n_fake;
    int          seed = 55492;

    slt_tx_ctrl i_slt_tx_ctrl (
        .ref_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .tx_bit_clk, .txd, .esc_en, .bcc_en,
        .sync_en, .data_en, .sync_byte_en, .data_byte_en,
        .length_carry_pulse, .dma_request, .fake_end, .tx_active
    );
    slt_modem i_slt_modem (.tx_bit_clk, .txd);

    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (dma_request === 1'b1) n_dma <= n_dma + 1;
        if (length_carry_pulse === 1'b1) n_carry <= n_carry + 1;
        if (fake_end === 1'b1) n_fake <= n_fake + 1;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task step(inout int k);
        @(posedge ref_clk);
        k++;
        if (k > 30000) begin
            err_total++;
            $display("[FAIL] %0t wait limit reached", $time);
            report_and_stop;
        end
    endtask
    // Entered right after a rising edge; leaves one edge after release.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        step(k);
        while (pready !== 1'b1) step(k);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    function automatic logic [15:0] vrc_char(input logic [15:0] c);
        logic [15:0] r;
        logic        p;
        r = c;
        p = ^(c & ((16'h0001 << (cur_n - 1)) - 16'h0001));
        if (cur_ctrl[3] && p != cur_ctrl[4]) r[cur_n - 1] = 1'b1;
        return r;
    endfunction
    task add_char(input logic [15:0] c);
        for (int i = 0; i < cur_n; i++) exp_q.push_back(c[i]);
    endtask
    task push_word(input logic [16:0] v);
        apb(1'b1, 8'h0c, {15'h0, v});
        if (cur_ctrl[1]) begin
            add_char({8'h00, v[7:0]});
            if (!v[16]) add_char({8'h00, v[15:8]});
        end else begin
            add_char(vrc_char(v[15:0]));
        end
    endtask
    task begin_case(input logic [7:0] ctrl, input int n);
        apb(1'b1, 8'h04, {20'h0, n[3:0], 8'h00});
        cur_ctrl = ctrl;
        cur_n = n;
        exp_q.delete();
        i_slt_modem.bits.delete();
        i_slt_modem.locked = 1'b0;
        n_dma = 0;
        n_carry = 0;
        n_fake = 0;
        apb(1'b1, 8'h00, {24'h0, ctrl});
    endtask
    task collect;
        int k;
        k = 0;
        while (i_slt_modem.bits.size() < exp_q.size()) step(k);
        foreach (exp_q[i]) check(i_slt_modem.bits[i], exp_q[i]);
    endtask
    task end_case;
        int k;
        collect;
        apb(1'b1, 8'h00, 32'h0);
        k = 0;
        while (tx_active !== 1'b0) step(k);
        repeat (2) @(posedge ref_clk);
        check(txd, 1'b1);
        $display("test done, %0d bits", exp_q.size());
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check(tx_active, 1'b0);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0000_0800);
        apb(1'b0, 8'h20, 32'h0);
        check(e, 1'b1);
        apb(1'b1, 8'h08, 32'h0000_0096);
        apb(1'b1, 8'h14, 32'h0000_0016);
        apb(1'b1, 8'h18, 32'h0000_00a5);
        // The first case overruns the FIFO so that writes must wait.
        for (int j = 0; j < 5; j++) begin
            begin_case(ctrl_t[j], n_t[j]);
            for (int i = 0; i < (j == 0 ? 10 : 3); i++) begin
                w = $random(seed);
                if (i == 0) w[0] = 1'b0;
                if (cur_ctrl[3]) w[cur_n - 1] = 1'b0;
                push_word({1'b0, w[15:0]});
            end
            end_case;
            check(n_dma, j == 0 ? 10 : 3);
            check(n_carry, j == 0 ? 10 : 3);
        end
        // The automatic block check must follow the odd last byte.
        begin_case(8'h83, 8);
        push_word(17'h0a512);
        push_word(17'h05e34);
        push_word(17'h1ff76);
        add_char(16'h00a5);
        end_case;
        check(n_fake, 1);
        check(n_carry, 6);
        check(n_dma, 3);
        // Pad fill runs first, so both requests must win over it.
        begin_case(8'h41, 8);
        add_char(16'h0016);
        add_char(16'h00a5);
        apb(1'b1, 8'h10, 32'h0000_0003);
        add_char(16'h00ff);
        end_case;
        begin_case(8'h25, 8);
        repeat (2) begin
            add_char(16'h0016);
            add_char(16'h0096);
        end
        collect;
        resetn <= 1'b0;
        @(posedge ref_clk);
        check(tx_active, 1'b0);
        check(txd, 1'b1);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check(tx_active, 1'b0);
        $display("reset test done");
        report_and_stop;
    end
endmodule // tb_top
